// ---- testbench/dcc_analog_model.sv ----
`timescale 1ns/1ns
// analog comparator cores with selectable inputs
module dcc_analog_model #(
	parameter logic [7:0] VREF_LEVEL = 8'h80
) (
	input wire logic clk,
	input wire logic [1:0] channel_on,
	input wire logic [1:0] positive_input_select,
	input wire logic [1:0] negative_input_select,
	input wire logic [15:0] pos_first,
	input wire logic [15:0] pos_second,
	input wire logic [7:0] ref_level,
	output logic [1:0] analog_result
);
	logic tog = 1'b0;
	// an idle core gives no steady level
	always @(posedge clk) tog <= ~tog;
	// an on core gives one only when positive level is above negative level
	always_comb begin
		for (int c = 0; c < 2; c++) begin
			analog_result[c] = tog;
			if (channel_on[c]) analog_result[c] =
				(positive_input_select[c] ? pos_second[c*8+:8] : pos_first[c*8+:8]) >
				(negative_input_select[c] ? VREF_LEVEL : ref_level);
		end
	end
endmodule

// ---- testbench/dcc_top_chk.sv ----
`timescale 1ns/1ns
// watches the top ports of the comparator control block
module dcc_top_chk (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] channel_on,
	input wire logic [1:0] comparator_output_pin_oe,
	input wire logic [1:0] result_valid,
	input wire logic comparator_irq
);
	logic [7:0] on_cnt;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// cycles channel one has stayed on
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) on_cnt <= 8'h00;
		else if (!channel_on[0]) on_cnt <= 8'h00;
		else if (on_cnt != 8'hFF) on_cnt <= on_cnt + 8'h01;
	end
	a_bresp_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped early");
	a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data not held");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	a_write_answer: assert property (s_axi_wvalid && s_axi_wready |-> ##[1:4] s_axi_bvalid)
		else $error("write answer late");
	a_valid_off: assert property (!channel_on[0] |=> !result_valid[0])
		else $error("result valid while off");
	a_valid_early: assert property (result_valid[0] |-> on_cnt >= 8'h62)
		else $error("result valid too soon");
	a_valid_late: assert property (on_cnt == 8'h68 |-> result_valid[0])
		else $error("result valid too late");
	a_pin_needs_on: assert property (comparator_output_pin_oe[0] |->
		channel_on[0] || $past(channel_on[0])) else $error("pin driven while off");
	a_irq_needs_on: assert property (comparator_irq |-> (|channel_on) || $past(|channel_on))
		else $error("interrupt with channels off");
endmodule

bind dcc_top dcc_top_chk u_chk (.clk, .rst_n, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
	.s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
	.channel_on, .comparator_output_pin_oe, .result_valid, .comparator_irq);

// ---- testbench/dual_comparator_control_tb_top.sv ----
`timescale 1ns/1ns
`include "dcc_defs.svh"
// bench for the comparator control block
module dual_comparator_control_tb_top;
	typedef struct packed {logic [11:0] a; logic [7:0] d; logic [7:0] e;} dcc_row_s;
	logic clk = 1'b0, rst_n = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
	logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic comparator_irq, irq, ch;
	logic [1:0] s_axi_bresp, s_axi_rresp, rsp, analog_result, positive_input_select;
	logic [1:0] negative_input_select, channel_on, comparator_output_pin;
	logic [1:0] comparator_output_pin_oe, result_valid;
	logic [15:0] pos_first = 16'h6464, pos_second = 16'hC8C8;
	logic [7:0] ref_level = 8'h96;
	int n_errors = 0, samples_checked = 0, k;
	dcc_row_s rows[6] = '{{12'h2B0, 8'h20, 8'h20}, {12'h2B0, 8'h30, 8'h32}, {12'h2B0, 8'h28, 8'h28},
		{12'h2B0, 8'h3C, 8'h3E}, {12'h2B4, 8'h34, 8'h36}, {12'h2B4, 8'h2C, 8'h2C}};
	dcc_top DUT (.clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .analog_result, .positive_input_select,
		.negative_input_select, .channel_on, .comparator_output_pin, .comparator_output_pin_oe,
		.result_valid, .comparator_irq, .irq);
	dcc_analog_model u_analog (.clk, .channel_on, .positive_input_select,
		.negative_input_select, .pos_first, .pos_second, .ref_level, .analog_result);
	// clock
	initial forever #50 clk = ~clk;
	// compare and count
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			n_errors++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask
	// bus write, each channel held until taken
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		logic aw;
		logic w;
		@(posedge clk);
		aw = 1'b1;
		w = 1'b1;
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (aw || w) begin
			@(posedge clk);
			if (s_axi_awready) aw = 1'b0;
			if (s_axi_wready) w = 1'b0;
			s_axi_awvalid <= aw;
			s_axi_wvalid <= w;
		end
		while (!s_axi_bvalid) @(posedge clk);
		rsp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	// bus read
	task automatic rd_reg(input logic [11:0] a);
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge clk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		while (!s_axi_rvalid) @(posedge clk);
		rd = s_axi_rdata;
		rsp = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	// verdict
	task automatic finish_test();
		$display("errors %0d checks %0d", n_errors, samples_checked);
		if (n_errors == 0 && samples_checked > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	// watchdog
	initial begin
		repeat (20000) @(posedge clk);
		n_errors++;
		finish_test();
	end
	// main sequence
	initial begin
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		rd_reg(`DCC_ADDR_CTRL1);
		chk("ctrl1 reset", 32'h0, rd);
		rd_reg(`DCC_ADDR_CTRL2);
		chk("ctrl2 reset", 32'h0, rd);
		wr(`DCC_ADDR_CTRL1, 8'h20);
		for (k = 0; k < 300 && !result_valid[0]; k++) @(posedge clk);
		chk("settle", 32'h1, k >= 95 && k <= 101);
		foreach (rows[i]) begin
			ch = rows[i].a[2];
			wr(rows[i].a, rows[i].d);
			repeat (5) @(posedge clk);
			rd_reg(rows[i].a);
			chk("ctrl", rows[i].e, rd & 32'h3E);
			chk("pins", rows[i].d[4:2], {positive_input_select[ch],
				negative_input_select[ch], comparator_output_pin_oe[ch]});
			chk("out pin", rows[i].d[2] & rows[i].e[1],
				comparator_output_pin[ch]);
		end
		wr(`DCC_ADDR_CTRL1, 8'h30);
		rd_reg(`DCC_ADDR_IRQ_STATUS);
		chk("status both", 32'h3, rd);
		wr(`DCC_ADDR_IRQ_MASK, 8'h03);
		wr(`DCC_ADDR_IRQ_ENABLE, 8'h81);
		chk("irq idle", 32'h0, {comparator_irq, irq});
		pos_second <= 16'hC832;
		repeat (6) @(posedge clk);
		chk("irq raised", 32'h3, {comparator_irq, irq});
		rd_reg(`DCC_ADDR_CTRL1);
		chk("flag set", 32'h31, rd);
		wr(`DCC_ADDR_IRQ_MASK, 8'h00);
		@(posedge clk);
		chk("masked", 32'h0, irq);
		rd_reg(`DCC_ADDR_IRQ_STATUS);
		chk("status", 32'h1, rd[0]);
		rd_reg(`DCC_ADDR_IRQ_STATUS);
		chk("status clear", 32'h0, rd);
		wr(`DCC_ADDR_CTRL1, 8'h30);
		@(posedge clk);
		chk("flag clear", 32'h0, comparator_irq);
		wr(`DCC_ADDR_IRQ_ENABLE, 8'h01);
		pos_second <= 16'hC8C8;
		repeat (6) @(posedge clk);
		chk("global off", 32'h0, comparator_irq);
		rd_reg(`DCC_ADDR_CTRL1);
		chk("flag again", 32'h33, rd);
		wr(`DCC_ADDR_CTRL1, 8'h00);
		repeat (3) @(posedge clk);
		rd_reg(`DCC_ADDR_CTRL1);
		chk("disabled", 32'h0, rd);
		chk("off outputs", 32'h0, {channel_on[0], result_valid[0]});
		// read with rready held back three cycles
		@(posedge clk);
		s_axi_araddr <= `DCC_ADDR_IRQ_ENABLE;
		s_axi_arvalid <= 1'b1;
		do @(posedge clk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		repeat (3) @(posedge clk);
		s_axi_rready <= 1'b1;
		@(posedge clk);
		chk("late rready", 32'h101, {s_axi_rvalid, s_axi_rdata[7:0]});
		s_axi_rready <= 1'b0;
		rd_reg(12'h3F0);
		chk("unmapped read", 32'h2, rsp);
		wr(12'h3F0, 8'h5A);
		chk("unmapped write", 32'h2, rsp);
		// reset in mid-run clears both control registers
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		chk("reset outs", 32'h0,
			{channel_on, comparator_output_pin_oe, irq});
		rd_reg(`DCC_ADDR_CTRL2);
		chk("ctrl2 after reset", 32'h0, rd);
		finish_test();
	end
endmodule

// ---- verilog/dcc_defs.svh ----
`ifndef DCC_DEFS_SVH
`define DCC_DEFS_SVH

// register byte addresses on the bus (index times four)
`define DCC_IDX_CTRL1 8'hAC
`define DCC_IDX_CTRL2 8'hAD
`define DCC_ADDR_CTRL1 12'h2B0
`define DCC_ADDR_CTRL2 12'h2B4
`define DCC_ADDR_IRQ_STATUS 12'h300
`define DCC_ADDR_IRQ_MASK 12'h304
`define DCC_ADDR_IRQ_ENABLE 12'h308
`define DCC_ADDR_STATUS 12'h30C

// control register fields
`define DCC_BIT_ON 5
`define DCC_BIT_POS 4
`define DCC_BIT_NEG 3
`define DCC_BIT_PIN 2
`define DCC_BIT_SYNC 1
`define DCC_BIT_FLAG 0
`define DCC_CTRL_RESET 8'h00
`define DCC_CTRL_WMASK 8'h3C

// interrupt enable register fields
`define DCC_BIT_CH1_IRQ 0
`define DCC_BIT_CH2_IRQ 1
`define DCC_BIT_GLOBAL_IRQ 7

// timing
`define DCC_CLK_HZ 10000000
`define DCC_SETTLE_US 10
`define DCC_SETTLE_CYCLES ((`DCC_SETTLE_US * `DCC_CLK_HZ + 999999) / 1000000)

`endif

// ---- verilog/dcc_pkg.sv ----
package dcc_pkg;
	typedef logic [7:0] dcc_ctrl_t;
	typedef enum logic [1:0] {
		DCC_RD_IDLE,
		DCC_RD_RESP
	} dcc_rd_e;
endpackage

// ---- verilog/dcc_top.sv ----
// Local design decision: register access over AXI4-Lite.
`timescale 1ns/1ns
`include "dcc_defs.svh"
module dcc_top (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [1:0] analog_result,
	output logic [1:0] positive_input_select,
	output logic [1:0] negative_input_select,
	output logic [1:0] channel_on,
	output logic [1:0] comparator_output_pin,
	output logic [1:0] comparator_output_pin_oe,
	output logic [1:0] result_valid,
	output logic comparator_irq,
	output logic irq
);
	// reset release
	logic rst_sync1;
	logic rst_sync;

	// per-channel state
	dcc_pkg::dcc_ctrl_t ctrl [2];
	logic [1:0] sync1;
	logic [1:0] synced_result;
	logic [1:0] synced_prev;
	logic [1:0] change_flag;
	logic [1:0] raw_prev;
	logic [1:0] raw_sync1;
	logic [1:0] raw_sync;
	logic [1:0] raw_seen;
	logic [7:0] settle_cnt [2];
	logic [1:0] wr_flag_zero;

	// interrupt state
	logic [7:0] irq_enable_second;
	logic [1:0] irq_status;
	logic [1:0] irq_mask;
	logic global_irq_enable;

	// bus state
	logic [11:0] wr_addr;
	logic [7:0] wr_byte;
	logic have_aw;
	logic have_w;
	logic wr_fire;
	logic [1:0] wr_ch;
	logic rd_fire;
	logic [1:0] rd_ch;
	logic [31:0] next_rdata;
	logic next_rerr;
	dcc_pkg::dcc_rd_e rd_state;

	// channel decode, used by both read and write paths
	function automatic logic [1:0] ch_hit(input logic [11:0] a);
		ch_hit = {a == `DCC_ADDR_CTRL2, a == `DCC_ADDR_CTRL1};
	endfunction

	// reset release through two flops
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_sync1 <= 1'b0;
			rst_sync <= 1'b0;
		end else begin
			rst_sync1 <= 1'b1;
			rst_sync <= rst_sync1;
		end
	end

	// write channel capture, address and data in either order
	always_ff @(posedge clk or negedge rst_sync) begin
		if (!rst_sync) begin
			have_aw <= 1'b0;
			have_w <= 1'b0;
			wr_addr <= 12'h000;
			wr_byte <= 8'h00;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'b00;
		end else begin
			s_axi_awready <= !have_aw && !s_axi_awready && !s_axi_bvalid;
			s_axi_wready <= !have_w && !s_axi_wready && !s_axi_bvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				have_aw <= 1'b1;
				wr_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				have_w <= 1'b1;
				// low byte taken only with its strobe; a write without wstrb[0] stores zero
				wr_byte <= s_axi_wstrb[0] ? s_axi_wdata[7:0] : 8'h00;
			end
			if (wr_fire) begin
				have_aw <= 1'b0;
				have_w <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (ch_hit(wr_addr) != 2'b00 ||
					wr_addr == `DCC_ADDR_IRQ_MASK ||
					wr_addr == `DCC_ADDR_IRQ_ENABLE ||
					wr_addr == `DCC_ADDR_IRQ_STATUS ||
					wr_addr == `DCC_ADDR_STATUS) ? 2'b00 : 2'b10;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// a write commits once address and data are both held
	assign wr_fire = have_aw && have_w && !s_axi_bvalid;
	assign wr_ch = wr_fire ? ch_hit(wr_addr) : 2'b00;

	// global enable sits in the top bit of the enable register
	assign global_irq_enable = irq_enable_second[`DCC_BIT_GLOBAL_IRQ];

	// interrupt enable register and status mask
	always_ff @(posedge clk or negedge rst_sync) begin
		if (!rst_sync) begin
			irq_enable_second <= 8'h00;
			irq_mask <= 2'b00;
		end else if (wr_fire) begin
			if (wr_addr == `DCC_ADDR_IRQ_ENABLE)
				irq_enable_second <= wr_byte & 8'h83;
			if (wr_addr == `DCC_ADDR_IRQ_MASK)
				irq_mask <= wr_byte[1:0];
		end
	end

	// per-channel control, synchronizer, flag and settle timer
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : gen_ch
			// writable bits only; reserved bits 7:6 are dropped
			always_ff @(posedge clk or negedge rst_sync) begin
				if (!rst_sync)
					ctrl[g] <= `DCC_CTRL_RESET;
				else if (wr_ch[g])
					ctrl[g] <= wr_byte & `DCC_CTRL_WMASK;
			end

			// software write with the flag bit at zero
			assign wr_flag_zero[g] = wr_ch[g] && !wr_byte[`DCC_BIT_FLAG];

			// two-stage synchronizer of the analog result
			always_ff @(posedge clk or negedge rst_sync) begin
				if (!rst_sync) begin
					sync1[g] <= 1'b0;
					synced_result[g] <= 1'b0;
					synced_prev[g] <= 1'b0;
				end else begin
					sync1[g] <= analog_result[g];
					// forced low while the channel is off
					synced_result[g] <= ctrl[g][`DCC_BIT_ON] && sync1[g];
					synced_prev[g] <= synced_result[g];
				end
			end

			// each raw result edge toggles a flop, works with clock stopped
			always_ff @(posedge analog_result[g] or negedge analog_result[g]
				or negedge rst_sync) begin
				if (!rst_sync)
					raw_prev[g] <= 1'b0;
				else
					raw_prev[g] <= !raw_prev[g];
			end

			// raw toggle brought onto the clock through two flops
			always_ff @(posedge clk or negedge rst_sync) begin
				if (!rst_sync) begin
					raw_sync1[g] <= 1'b0;
					raw_sync[g] <= 1'b0;
					raw_seen[g] <= 1'b0;
				end else begin
					raw_sync1[g] <= raw_prev[g];
					raw_sync[g] <= raw_sync1[g];
					raw_seen[g] <= raw_sync[g];
				end
			end

			// change flag: set beats software clear
			always_ff @(posedge clk or negedge rst_sync) begin
				if (!rst_sync)
					change_flag[g] <= 1'b0;
				else if (!ctrl[g][`DCC_BIT_ON])
					change_flag[g] <= 1'b0;
				else if (synced_result[g] != synced_prev[g])
					change_flag[g] <= 1'b1;
				else if (wr_flag_zero[g])
					change_flag[g] <= 1'b0;
			end

			// settle timer from each set of enable, cleared while the enable is off
			always_ff @(posedge clk or negedge rst_sync) begin
				if (!rst_sync) begin
					settle_cnt[g] <= 8'h00;
					result_valid[g] <= 1'b0;
				end else if (!ctrl[g][`DCC_BIT_ON]) begin
					settle_cnt[g] <= 8'h00;
					result_valid[g] <= 1'b0;
				end else if (settle_cnt[g] != 8'(`DCC_SETTLE_CYCLES)) begin
					settle_cnt[g] <= settle_cnt[g] + 8'h01;
				end else begin
					result_valid[g] <= 1'b1;
				end
			end

			// analog steering and pin drive
			always_ff @(posedge clk or negedge rst_sync) begin
				if (!rst_sync) begin
					positive_input_select[g] <= 1'b0;
					negative_input_select[g] <= 1'b0;
					channel_on[g] <= 1'b0;
					comparator_output_pin_oe[g] <= 1'b0;
				end else begin
					positive_input_select[g] <= ctrl[g][`DCC_BIT_POS];
					negative_input_select[g] <= ctrl[g][`DCC_BIT_NEG];
					channel_on[g] <= ctrl[g][`DCC_BIT_ON];
					comparator_output_pin_oe[g] <=
						ctrl[g][`DCC_BIT_ON] && ctrl[g][`DCC_BIT_PIN];
				end
			end

			// raw unsynchronized result registered to the pin, gated by the enable and pin bits of ctrl
			always_ff @(posedge clk or negedge rst_sync) begin
				if (!rst_sync)
					comparator_output_pin[g] <= 1'b0;
				else
					comparator_output_pin[g] <= ctrl[g][`DCC_BIT_ON] &&
						ctrl[g][`DCC_BIT_PIN] && analog_result[g];
			end
		end
	endgenerate

	// sticky status bits: set on any synced or raw result change of an on channel, cleared on status read
	always_ff @(posedge clk or negedge rst_sync) begin
		if (!rst_sync)
			irq_status <= 2'b00;
		else
			irq_status <= (rd_fire && s_axi_araddr == `DCC_ADDR_IRQ_STATUS ? 2'b00 : irq_status)
				| ((synced_result ^ synced_prev) & channel_on)
				| ((raw_sync ^ raw_seen) & channel_on);
	end

	// interrupt outputs
	always_ff @(posedge clk or negedge rst_sync) begin
		if (!rst_sync) begin
			comparator_irq <= 1'b0;
			irq <= 1'b0;
		end else begin
			comparator_irq <= global_irq_enable &&
				|(change_flag & irq_enable_second[1:0]);
			irq <= |(irq_status & irq_mask);
		end
	end

	// read strobe and the channel its address picks
	assign rd_fire = s_axi_arvalid && s_axi_arready;
	assign rd_ch = ch_hit(s_axi_araddr);

	// read data mux
	always_comb begin
		next_rdata = 32'h0000_0000;
		next_rerr = 1'b0;
		case (s_axi_araddr)
			`DCC_ADDR_CTRL1, `DCC_ADDR_CTRL2: begin
				for (int i = 0; i < 2; i++) begin
					if (rd_ch[i])
						next_rdata[7:0] = {ctrl[i][7:2], synced_result[i], change_flag[i]};
				end
			end
			`DCC_ADDR_IRQ_STATUS: next_rdata[1:0] = irq_status;
			`DCC_ADDR_IRQ_MASK: next_rdata[1:0] = irq_mask;
			`DCC_ADDR_IRQ_ENABLE: next_rdata[7:0] = irq_enable_second;
			`DCC_ADDR_STATUS: next_rdata[5:0] = {raw_sync, result_valid, synced_result};
			default: next_rerr = 1'b1;
		endcase
	end

	// read channel
	always_ff @(posedge clk or negedge rst_sync) begin
		if (!rst_sync) begin
			rd_state <= dcc_pkg::DCC_RD_IDLE;
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= 2'b00;
		end else begin
			case (rd_state)
				dcc_pkg::DCC_RD_IDLE: begin
					s_axi_arready <= !s_axi_arready;
					if (rd_fire) begin
						s_axi_arready <= 1'b0;
						s_axi_rvalid <= 1'b1;
						s_axi_rdata <= next_rdata;
						s_axi_rresp <= next_rerr ? 2'b10 : 2'b00;
						rd_state <= dcc_pkg::DCC_RD_RESP;
					end
				end
				dcc_pkg::DCC_RD_RESP: begin
					if (s_axi_rready) begin
						s_axi_rvalid <= 1'b0;
						rd_state <= dcc_pkg::DCC_RD_IDLE;
					end
				end
				default: rd_state <= dcc_pkg::DCC_RD_IDLE;
			endcase
		end
	end
endmodule
